// ===== hw/fbm_block_mem.sv
// Overview of operation
// R1: normal mode: write leaves port output unchanged
// R2: write-through: written word shows on output
// R3: read-before-write: old word shows on output
// R4: fifo write port: data, clock enable, enable, clock
// R5: separate fifo read port with same controls
// R6: four flags: full, almost full/empty, empty
// R7: full flags update on write clock
// R8: empty flags update on read clock
// R9: full threshold from one to depth minus one
// R10: almost thresholds one to full minus one
// R11: fifo reset clears both pointers and flags
// R12: rewind resets only the read pointer
// R13: output latches clear sync or async
// R14: local clear affects only its own port
// R15: chip-wide reset clears both output latches
// R16: user avoids full writes, empty reads, tracks packets
//
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
module fbm_block_mem #(
  parameter int AW = fbm_pkg::AW_DEF,
  parameter int DW = fbm_pkg::DW_DEF
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  input wire logic [DW-1:0] write_data,
  input wire logic write_clock_enable,
  input wire logic write_enable,
  input wire logic write_clock,
  output logic [DW-1:0] read_data,
  input wire logic read_clock_enable,
  input wire logic read_strobe,
  input wire logic read_clock,
  input wire logic fifo_reset,
  input wire logic read_pointer_rewind,
  output logic full,
  output logic almost_full,
  output logic almost_empty,
  output logic empty,
  input wire logic a_en,
  input wire logic a_we,
  input wire logic [AW-1:0] a_addr,
  input wire logic [DW-1:0] a_wdata,
  output logic [DW-1:0] a_rdata,
  input wire logic b_en,
  input wire logic [AW-1:0] b_addr,
  input wire logic port_a_latch_clear,
  input wire logic port_b_latch_clear,
  input wire logic chip_wide_reset_n
);
  localparam int DEPTH = 1 << AW;
  localparam logic [AW:0] THR_MAX = (AW+1)'(DEPTH - 1);

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (AW < fbm_pkg::AW_MIN || AW > fbm_pkg::AW_MAX ||
      DW < 1 || DW > fbm_pkg::DW_MAX) begin : g_bad_param
    $error("unsupported address or data width");
  end

  function automatic logic in_range(input logic [31:0] v,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [fbm_pkg::SY_W-1:0] sy1_ff, sy2_ff, sy3_ff;

  // two flops per pin; third stage only feeds clock edge detect
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sy1_ff <= fbm_pkg::SY_RST;
      sy2_ff <= fbm_pkg::SY_RST;
      sy3_ff <= fbm_pkg::SY_RST;
    end else begin
      sy1_ff <= {chip_wide_reset_n, port_b_latch_clear,
                 port_a_latch_clear, read_pointer_rewind, fifo_reset,
                 read_clock, write_clock};
      sy2_ff <= sy1_ff;
      sy3_ff <= sy2_ff;
    end
  end

  logic wr_edge, rd_edge, fifo_clr, rewind, cwr_low;
  assign wr_edge = sy2_ff[fbm_pkg::SY_WCLK] & ~sy3_ff[fbm_pkg::SY_WCLK];
  assign rd_edge = sy2_ff[fbm_pkg::SY_RCLK] & ~sy3_ff[fbm_pkg::SY_RCLK];
  assign fifo_clr = sy2_ff[fbm_pkg::SY_FRST];
  assign rewind = sy2_ff[fbm_pkg::SY_RWND];
  assign cwr_low = ~sy2_ff[fbm_pkg::SY_CWR];

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  logic ph_wr_ff;
  logic [7:0] ph_addr_ff;
  logic acc;
  logic [31:0] hrdata_ff;
  logic [31:0] rd_word;

  // zero wait states; every access answers OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign acc = hsel & htrans[1] & hready;

  // address phase capture; only word writes are honoured
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ph_wr_ff <= 1'b0;
      ph_addr_ff <= 8'h00;
    end else begin
      ph_wr_ff <= acc & hwrite & (hsize == 3'h2);
      if (acc) begin
        ph_addr_ff <= haddr[7:0];
      end
    end
  end

  logic wr_ctrl, wr_full, wr_afull, wr_aempty, wr_istat, wr_imask;
  assign wr_ctrl = ph_wr_ff && (ph_addr_ff == fbm_pkg::OFS_CTRL);
  assign wr_full = ph_wr_ff && (ph_addr_ff == fbm_pkg::OFS_FULL_THR);
  assign wr_afull = ph_wr_ff && (ph_addr_ff == fbm_pkg::OFS_AFULL_THR);
  assign wr_aempty = ph_wr_ff && (ph_addr_ff == fbm_pkg::OFS_AEMPTY_THR);
  assign wr_istat = ph_wr_ff && (ph_addr_ff == fbm_pkg::OFS_INT_STAT);
  assign wr_imask = ph_wr_ff && (ph_addr_ff == fbm_pkg::OFS_INT_MASK);

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [fbm_pkg::CTRL_W-1:0] ctrl_ff;
  logic [AW:0] full_thr_ff, afull_thr_ff, aempty_thr_ff;
  logic [fbm_pkg::INT_W-1:0] int_stat_ff, int_mask_ff;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_ff <= fbm_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff <= hwdata[fbm_pkg::CTRL_W-1:0];
    end
  end

  // out-of-range threshold writes are dropped, old value stays
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      full_thr_ff <= (AW+1)'(DEPTH - fbm_pkg::FULL_THR_MARGIN);
    end else if (wr_full &&
                 in_range(hwdata, 32'(afull_thr_ff) + 32'h1,
                          32'(THR_MAX)) &&
                 (hwdata > 32'(aempty_thr_ff))) begin
      full_thr_ff <= hwdata[AW:0]; // R9
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      afull_thr_ff <= (AW+1)'(DEPTH - fbm_pkg::AFULL_THR_MARGIN);
      aempty_thr_ff <= (AW+1)'(fbm_pkg::AEMPTY_THR_RST);
    end else begin
      if (wr_afull &&
          in_range(hwdata, 32'h1, 32'(full_thr_ff) - 32'h1)) begin
        afull_thr_ff <= hwdata[AW:0]; // R10
      end
      if (wr_aempty &&
          in_range(hwdata, 32'h1, 32'(full_thr_ff) - 32'h1)) begin
        aempty_thr_ff <= hwdata[AW:0]; // R10
      end
    end
  end

  logic fifo_mode, ram_mode;
  fbm_pkg::fbm_wmode_t wmode;
  assign fifo_mode = ctrl_ff[fbm_pkg::CTRL_FIFO_BIT];
  assign ram_mode = ~fifo_mode;
  assign wmode = fbm_pkg::fbm_wmode_t'(ctrl_ff[fbm_pkg::CTRL_WM_LSB +: 2]);

  // ---------------------------------------------------------------
  // fifo pointers
  // ---------------------------------------------------------------
  logic [AW:0] wptr_ff, rptr_ff, nxt_wptr, nxt_rptr, count, nxt_count;
  logic full_ff, afull_ff, aempty_ff, empty_ff;
  logic wr_try, wr_go, rd_try, rd_go;

  assign count = wptr_ff - rptr_ff;
  assign wr_try = fifo_mode & wr_edge & write_clock_enable & write_enable;
  assign rd_try = fifo_mode & rd_edge & read_clock_enable & read_strobe;
  // blocking on the flag is a safety net for misbehaving fabric
  assign wr_go = wr_try & ~full_ff & ~fifo_clr; // R4 R16
  assign rd_go = rd_try & ~empty_ff & ~fifo_clr & ~rewind; // R5 R16

  // rewind takes priority over a read in the same cycle
  always_comb begin
    nxt_wptr = wptr_ff;
    nxt_rptr = rptr_ff;
    if (fifo_clr) begin
      nxt_wptr = '0; // R11
      nxt_rptr = '0; // R11
    end else begin
      if (wr_go) begin
        nxt_wptr = wptr_ff + 1'b1;
      end
      if (rewind) begin
        nxt_rptr = '0; // R12
      end else if (rd_go) begin
        nxt_rptr = rptr_ff + 1'b1;
      end
    end
  end
  assign nxt_count = nxt_wptr - nxt_rptr;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
    end else begin
      wptr_ff <= nxt_wptr;
      rptr_ff <= nxt_rptr;
    end
  end

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  // write-side flags move only on write clock edges or fifo reset, so may lag reads
  always_ff @(posedge sys_clk) begin
    if (srst || fifo_clr) begin
      full_ff <= 1'b0; // R11
      afull_ff <= 1'b0;
    end else if (wr_edge) begin
      full_ff <= (nxt_count >= full_thr_ff); // R6 R7
      afull_ff <= (nxt_count >= afull_thr_ff); // R6 R7
    end
  end

  // read-side flags move only on read clock edges or fifo reset; empty is count 0
  always_ff @(posedge sys_clk) begin
    if (srst || fifo_clr) begin
      empty_ff <= 1'b1; // R11
      aempty_ff <= 1'b1;
    end else if (rd_edge) begin
      empty_ff <= (nxt_count == '0); // R6 R8
      aempty_ff <= (nxt_count <= aempty_thr_ff); // R6 R8
    end
  end

  assign full = full_ff;
  assign almost_full = afull_ff;
  assign almost_empty = aempty_ff;
  assign empty = empty_ff;

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  logic [3:0] flg_prev_ff;
  logic [fbm_pkg::INT_W-1:0] ev, iclr;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      flg_prev_ff <= 4'hc; // flag reset levels, so no false edge
    end else begin
      flg_prev_ff <= {empty_ff, aempty_ff, afull_ff, full_ff};
    end
  end

  always_comb begin
    ev = '0;
    ev[fbm_pkg::INT_FULL] = full_ff & ~flg_prev_ff[0];
    ev[fbm_pkg::INT_AFULL] = afull_ff & ~flg_prev_ff[1];
    ev[fbm_pkg::INT_AEMPTY] = aempty_ff & ~flg_prev_ff[2];
    ev[fbm_pkg::INT_EMPTY] = empty_ff & ~flg_prev_ff[3];
    ev[fbm_pkg::INT_OVF] = wr_try & full_ff;
    ev[fbm_pkg::INT_UDF] = rd_try & empty_ff;
  end

  assign iclr = wr_istat ? hwdata[fbm_pkg::INT_W-1:0] : '0;

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      int_stat_ff <= '0;
      int_mask_ff <= '0;
    end else begin
      int_stat_ff <= (int_stat_ff & ~iclr) | ev;
      if (wr_imask) begin
        int_mask_ff <= hwdata[fbm_pkg::INT_W-1:0];
      end
    end
  end

  assign irq = |(int_stat_ff & int_mask_ff);

  // ---------------------------------------------------------------
  // register read path
  // ---------------------------------------------------------------
  always_comb begin
    rd_word = '0;
    case (haddr[7:0])
      fbm_pkg::OFS_CTRL: rd_word[fbm_pkg::CTRL_W-1:0] = ctrl_ff;
      fbm_pkg::OFS_FULL_THR: rd_word[AW:0] = full_thr_ff;
      fbm_pkg::OFS_AFULL_THR: rd_word[AW:0] = afull_thr_ff;
      fbm_pkg::OFS_AEMPTY_THR: rd_word[AW:0] = aempty_thr_ff;
      fbm_pkg::OFS_FLAGS: begin
        rd_word[3:0] = {empty_ff, aempty_ff, afull_ff, full_ff};
        rd_word[fbm_pkg::FLG_CNT_LSB +: AW+1] = count;
      end
      fbm_pkg::OFS_INT_STAT: rd_word[fbm_pkg::INT_W-1:0] = int_stat_ff;
      fbm_pkg::OFS_INT_MASK: rd_word[fbm_pkg::INT_W-1:0] = int_mask_ff;
      default: rd_word = '0;
    endcase
  end

  // read data is sampled in the address phase, held in data phase
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hrdata_ff <= '0;
    end else if (acc && !hwrite) begin
      hrdata_ff <= rd_word;
    end
  end
  assign hrdata = hrdata_ff;

  // ---------------------------------------------------------------
  // memory array
  // ---------------------------------------------------------------
  logic [DW-1:0] mem [DEPTH];
  logic a_wr;
  logic [DW-1:0] a_old, b_word, fifo_word;

  assign a_wr = ram_mode & a_en & a_we;
  assign a_old = mem[a_addr];
  assign b_word = mem[b_addr];
  assign fifo_word = mem[rptr_ff[AW-1:0]];

  // port A owns the array in ram mode, the fifo writer otherwise
  always_ff @(posedge sys_clk) begin
    if (a_wr) begin
      mem[a_addr] <= a_wdata;
    end else if (wr_go) begin
      mem[wptr_ff[AW-1:0]] <= write_data; // R4
    end
  end

  // ---------------------------------------------------------------
  // output latches
  // ---------------------------------------------------------------
  fbm_latch_if #(.DW(DW)) pa_if ();
  fbm_latch_if #(.DW(DW)) pb_if ();

  // port A load follows the selected write behaviour
  always_comb begin
    pa_if.load = 1'b0;
    pa_if.din = a_old;
    if (ram_mode && a_en) begin
      if (!a_we) begin
        pa_if.load = 1'b1;
      end else begin
        case (wmode)
          fbm_pkg::WM_THROUGH: begin
            pa_if.load = 1'b1; // R2
            pa_if.din = a_wdata; // R2
          end
          fbm_pkg::WM_RBW: begin
            pa_if.load = 1'b1; // R3
          end
          default: begin
            pa_if.load = 1'b0; // R1
          end
        endcase
      end
    end
  end

  // port B serves ram reads and fifo reads
  assign pb_if.load = rd_go | (ram_mode & b_en); // R5
  assign pb_if.din = rd_go ? fifo_word : b_word;
  assign pa_if.clr = sy2_ff[fbm_pkg::SY_CLRA] | cwr_low; // R14 R15
  assign pb_if.clr = sy2_ff[fbm_pkg::SY_CLRB] | cwr_low; // R14 R15
  assign pa_if.async_mode = ctrl_ff[fbm_pkg::CTRL_ASYNC_A_BIT];
  assign pb_if.async_mode = ctrl_ff[fbm_pkg::CTRL_ASYNC_B_BIT];

  fbm_out_latch #(.DW(DW)) u_latch_a (
    .sys_clk(sys_clk),
    .srst(srst),
    .lif(pa_if.latch)
  );

  fbm_out_latch #(.DW(DW)) u_latch_b (
    .sys_clk(sys_clk),
    .srst(srst),
    .lif(pb_if.latch)
  );

  assign a_rdata = pa_if.dout;
  assign read_data = pb_if.dout;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_norm_hold;
    @(posedge sys_clk) disable iff (srst)
    (a_wr && wmode != fbm_pkg::WM_THROUGH && wmode != fbm_pkg::WM_RBW
     && !pa_if.clr) ##1 !pa_if.clr |-> $stable(a_rdata);
  endproperty
  a_norm_hold: assert property (p_norm_hold) // R1
    else $error("normal write changed port A output");

  property p_thru;
    @(posedge sys_clk) disable iff (srst)
    (a_wr && wmode == fbm_pkg::WM_THROUGH && !pa_if.clr) ##1
    !pa_if.clr |-> (a_rdata == $past(a_wdata));
  endproperty
  a_thru: assert property (p_thru) // R2
    else $error("write-through word missing on port A");

  property p_rbw;
    @(posedge sys_clk) disable iff (srst)
    (a_wr && wmode == fbm_pkg::WM_RBW && !pa_if.clr) ##1
    !pa_if.clr |-> (a_rdata == $past(a_old));
  endproperty
  a_rbw: assert property (p_rbw) // R3
    else $error("old word missing on read-before-write");

  property p_wr_adv;
    @(posedge sys_clk) disable iff (srst)
    wr_go |=> (wptr_ff == (AW+1)'($past(wptr_ff) + 1'b1));
  endproperty
  a_wr_adv: assert property (p_wr_adv) // R4
    else $error("fifo write did not advance write pointer");

  property p_rd_data;
    @(posedge sys_clk) disable iff (srst)
    (rd_go && !pb_if.clr) ##1 !pb_if.clr |->
    (read_data == $past(fifo_word));
  endproperty
  a_rd_data: assert property (p_rd_data) // R5
    else $error("fifo read delivered wrong word");

  property p_full_wclk;
    @(posedge sys_clk) disable iff (srst)
    (!wr_edge && !fifo_clr) |=> ($stable(full_ff) && $stable(afull_ff));
  endproperty
  a_full_wclk: assert property (p_full_wclk) // R7
    else $error("full flags moved without write clock");

  property p_empty_rclk;
    @(posedge sys_clk) disable iff (srst)
    (!rd_edge && !fifo_clr) |=>
    ($stable(empty_ff) && $stable(aempty_ff));
  endproperty
  a_empty_rclk: assert property (p_empty_rclk) // R8
    else $error("empty flags moved without read clock");

  property p_thr_full;
    @(posedge sys_clk) disable iff (srst)
    (full_thr_ff >= (AW+1)'(1)) && (full_thr_ff <= THR_MAX);
  endproperty
  a_thr_full: assert property (p_thr_full) // R9
    else $error("full threshold out of range");

  property p_thr_almost;
    @(posedge sys_clk) disable iff (srst)
    (afull_thr_ff >= (AW+1)'(1)) && (afull_thr_ff < full_thr_ff) &&
    (aempty_thr_ff >= (AW+1)'(1)) && (aempty_thr_ff < full_thr_ff);
  endproperty
  a_thr_almost: assert property (p_thr_almost) // R10
    else $error("almost threshold out of range");

  property p_fifo_clr;
    @(posedge sys_clk) disable iff (srst)
    fifo_clr |=> (wptr_ff == '0 && rptr_ff == '0 && empty_ff &&
                  aempty_ff && !full_ff && !afull_ff);
  endproperty
  a_fifo_clr: assert property (p_fifo_clr) // R11
    else $error("fifo reset left pointers or flags");

  property p_rewind;
    @(posedge sys_clk) disable iff (srst)
    (rewind && !fifo_clr && !wr_go) |=>
    (rptr_ff == '0 && wptr_ff == $past(wptr_ff));
  endproperty
  a_rewind: assert property (p_rewind) // R12
    else $error("rewind disturbed write pointer");

  property p_chip_clr;
    @(posedge sys_clk) disable iff (srst)
    cwr_low |=> (a_rdata == '0 && read_data == '0);
  endproperty
  a_chip_clr: assert property (p_chip_clr) // R15
    else $error("chip reset did not clear both latches");

  c_full: cover property (@(posedge sys_clk) disable iff (srst)
    $rose(full_ff));
  c_rewind: cover property (@(posedge sys_clk) disable iff (srst)
    rewind && count != '0);
  c_thru: cover property (@(posedge sys_clk) disable iff (srst)
    a_wr && wmode == fbm_pkg::WM_THROUGH);
  c_irq: cover property (@(posedge sys_clk) disable iff (srst)
    $rose(irq));
endmodule : fbm_block_mem

// ===== hw/fbm_latch_if.sv
`timescale 1ns/100ps
interface fbm_latch_if #(
  parameter int DW = 8
);
  logic load;
  logic [DW-1:0] din;
  logic clr;
  logic async_mode;
  logic [DW-1:0] dout;

  // memory core side drives, latch side holds the word
  modport owner (output load, output din, output clr, output async_mode,
                 input dout);
  modport latch (input load, input din, input clr, input async_mode,
                 output dout);
endinterface : fbm_latch_if

// ===== hw/fbm_out_latch.sv
`timescale 1ns/100ps
module fbm_out_latch #(
  parameter int DW = 8
) (
  input wire logic sys_clk,
  input wire logic srst,
  fbm_latch_if.latch lif
);
  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if ($bits(lif.din) != DW) begin : g_bad_width
    $error("latch width does not match interface");
  end

  logic [DW-1:0] dout_ff;
  logic aclr;

  // clr comes from flops, so the async path sees no glitches
  assign aclr = lif.clr & lif.async_mode;

  // output latch, cleared sync or async as configured
  always_ff @(posedge sys_clk or posedge aclr) begin
    if (aclr) begin
      dout_ff <= '0; // R13
    end else if (srst || lif.clr) begin
      dout_ff <= '0; // R13
    end else if (lif.load) begin
      dout_ff <= lif.din;
    end
  end

  assign lif.dout = dout_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_clr_zero;
    @(posedge sys_clk) disable iff (srst)
    lif.clr |=> (lif.dout == '0);
  endproperty
  a_clr_zero: assert property (p_clr_zero) // R14
    else $error("latch not cleared after local clear");

  property p_async_now;
    @(posedge sys_clk) disable iff (srst)
    (lif.clr && lif.async_mode) |-> (lif.dout == '0);
  endproperty
  a_async_now: assert property (p_async_now) // R13
    else $error("async clear did not act at once");
endmodule : fbm_out_latch

// ===== hw/fbm_pkg.sv
package fbm_pkg;
  // ---------------------------------------------------------------
  // geometry defaults
  // ---------------------------------------------------------------
  localparam int AW_DEF = 4;
  localparam int DW_DEF = 8;
  localparam int AW_MIN = 3;
  localparam int AW_MAX = 12;
  localparam int DW_MAX = 24;

  // ---------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FULL_THR = 8'h04;
  localparam logic [7:0] OFS_AFULL_THR = 8'h08;
  localparam logic [7:0] OFS_AEMPTY_THR = 8'h0c;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_INT_STAT = 8'h14;
  localparam logic [7:0] OFS_INT_MASK = 8'h18;

  // ---------------------------------------------------------------
  // control fields and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_W = 5;
  localparam int CTRL_FIFO_BIT = 0;
  localparam int CTRL_WM_LSB = 1;
  localparam int CTRL_ASYNC_A_BIT = 3;
  localparam int CTRL_ASYNC_B_BIT = 4;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam int FULL_THR_MARGIN = 1;
  localparam int AFULL_THR_MARGIN = 4;
  localparam int AEMPTY_THR_RST = 3;
  localparam int FLG_CNT_LSB = 8;

  // ---------------------------------------------------------------
  // interrupt status bits
  // ---------------------------------------------------------------
  localparam int INT_FULL = 0;
  localparam int INT_AFULL = 1;
  localparam int INT_AEMPTY = 2;
  localparam int INT_EMPTY = 3;
  localparam int INT_OVF = 4;
  localparam int INT_UDF = 5;
  localparam int INT_W = 6;

  // ---------------------------------------------------------------
  // synchroniser lanes
  // ---------------------------------------------------------------
  localparam int SY_WCLK = 0;
  localparam int SY_RCLK = 1;
  localparam int SY_FRST = 2;
  localparam int SY_RWND = 3;
  localparam int SY_CLRA = 4;
  localparam int SY_CLRB = 5;
  localparam int SY_CWR = 6;
  localparam int SY_W = 7;
  localparam logic [6:0] SY_RST = 7'h40;

  typedef enum logic [1:0] {WM_NORMAL, WM_THROUGH, WM_RBW} fbm_wmode_t;
endpackage : fbm_pkg

// ===== verif/fbm_fabric.sv
`timescale 1ns/100ps
// user logic on the fifo pins; clock phases last four system cycles
// so every edge clears the two-flop detect delay
module fbm_fabric (
  input wire logic sys_clk,
  output logic [7:0] write_data,
  output logic write_clock_enable,
  output logic write_enable,
  output logic write_clock,
  output logic read_clock_enable,
  output logic read_strobe,
  output logic read_clock
);
  initial begin
    {write_clock_enable, write_enable, write_clock} = 3'h0;
    {read_clock_enable, read_strobe, read_clock} = 3'h0;
    write_data = 8'h00;
  end

  // one write or read edge, controls held well past detection
  task automatic xfer(input logic w, input logic [7:0] d, input logic en);
    @(posedge sys_clk);
    if (w) begin
      write_data <= d;
      {write_clock_enable, write_enable, write_clock} <= {en, en, 1'b1};
    end else begin
      {read_clock_enable, read_strobe, read_clock} <= {en, en, 1'b1};
    end
    repeat (4) @(posedge sys_clk);
    {write_clock, read_clock} <= 2'h0;
    repeat (4) @(posedge sys_clk);
    write_data <= ~d; // released data never shows the old word
    {write_clock_enable, write_enable} <= 2'h0;
    {read_clock_enable, read_strobe} <= 2'h0;
  endtask : xfer
endmodule : fbm_fabric

// ===== verif/tb_fbm_block_mem.sv
`timescale 1ns/100ps
module tb_fbm_block_mem;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic hready, hreadyout, hresp, irq, full, almost_full;
  logic almost_empty, empty, write_clock_enable, write_enable;
  logic write_clock, read_clock_enable, read_strobe, read_clock;
  logic [7:0] write_data, read_data, a_rdata, a_wdata = 8'h0, d;
  logic a_en = 1'b0, a_we = 1'b0, b_en = 1'b0;
  logic [3:0] a_addr = 4'h0, b_addr = 4'h0, a;
  logic [4:0] pin = 5'h0;
  logic [7:0] mem [16];
  logic [7:0] q [$];
  logic [31:0] seed = 32'h0000ba6e;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  wire port_a_latch_clear = pin[0];
  wire port_b_latch_clear = pin[1];
  wire chip_wide_reset_n = ~pin[2];
  wire fifo_reset = pin[3];
  wire read_pointer_rewind = pin[4];
  assign hready = hreadyout;

  fbm_block_mem i_dut (.*);
  fbm_fabric u_fab (.*);

  initial forever #12.5 sys_clk = ~sys_clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic stop_test();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  // single ahb transfer; waits on hready, never on a fixed count
  task automatic ahb(input logic w, input logic [7:0] ad,
                     input logic [31:0] wd);
    @(posedge sys_clk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, ad};
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    {hsel, htrans} <= 3'h0;
    hwdata <= wd;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    r = hrdata;
    #1;
  endtask : ahb

  // port a access with port b reading the neighbouring word
  task automatic ram(input logic we, input logic [3:0] ad,
                     input logic [7:0] wd);
    @(posedge sys_clk);
    {a_en, a_we, a_addr, a_wdata} <= {1'b1, we, ad, wd};
    {b_en, b_addr} <= {1'b1, ad ^ 4'h1};
    @(posedge sys_clk);
    {a_en, a_we, b_en} <= 3'h0;
    #1;
  endtask : ram

  task automatic pulse(input int i);
    @(posedge sys_clk);
    pin[i] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    pin[i] <= 1'b0;
    repeat (5) @(posedge sys_clk);
  endtask : pulse

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 8000) begin
      error_cnt++;
      stop_test();
    end
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    ahb(0, 8'h04, 0); chk(r, 15);
    ahb(0, 8'h08, 0); chk(r, 12);
    ahb(0, 8'h1c, 0); chk(r, 0);
    chk(hresp, 0);
    ahb(1, 8'h04, 16);
    ahb(0, 8'h04, 0); chk(r, 15);
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      mem[i] = r[7:0];
      ram(1'b1, i[3:0], mem[i]);
    end
    for (int m = 0; m < 3; m++) begin
      ahb(1, 8'h00, m << 1);
      r = rnd();
      {d, a} = r[11:0];
      ram(1'b0, a ^ 4'h1, 8'h00);
      chk(read_data, mem[a]);
      ram(1'b1, a, d);
      chk(a_rdata, m == 0 ? mem[a ^ 4'h1] : m == 1 ? d : mem[a]);
      mem[a] = d;
    end
    for (int s = 0; s < 2; s++) begin
      ahb(1, 8'h00, s * 24);
      for (int p = 0; p < 2; p++) begin
        ram(1'b0, 4'h2, 8'h00);
        pulse(p);
        chk(a_rdata, p ? mem[2] : 8'h00);
        chk(read_data, p ? 8'h00 : mem[3]);
      end
    end
    ram(1'b0, 4'h2, 8'h00);
    pulse(2);
    chk(read_data, 0);
    chk(a_rdata, 0);
    ahb(1, 8'h00, 1);
    ahb(1, 8'h18, 1);
    // the sixteenth push is a deliberate write into a full fifo
    repeat (16) begin
      r = rnd();
      u_fab.xfer(1'b1, r[7:0], 1'b1);
      if (q.size() < 15) q.push_back(r[7:0]);
      chk(full, q.size() >= 15);
      chk(almost_full, q.size() >= 12);
    end
    ahb(0, 8'h10, 0);
    chk(r, 32'h0f0f);
    chk(irq, 1);
    ahb(1, 8'h14, 1);
    chk(irq, 0);
    u_fab.xfer(1'b0, 8'h00, 1'b0);
    chk(empty, 0);
    while (q.size() > 0) begin
      u_fab.xfer(1'b0, 8'h00, 1'b1);
      chk(read_data, q.pop_front());
      chk(almost_empty, q.size() <= 3);
      chk(empty, q.size() == 0);
    end
    u_fab.xfer(1'b1, 8'h00, 1'b0);
    chk(full, 0);
    pulse(3);
    chk({full, empty, almost_empty}, 3'h3);
    repeat (3) begin
      r = rnd();
      u_fab.xfer(1'b1, r[7:0], 1'b1);
      q.push_back(r[7:0]);
    end
    for (int k = 0; k < 6; k++) begin
      if (k == 3) pulse(4);
      if (k % 3 == 0) u_fab.xfer(1'b0, 8'h00, 1'b0);
      u_fab.xfer(1'b0, 8'h00, 1'b1);
      chk(read_data, q[k % 3]);
    end
    stop_test();
  end
endmodule : tb_fbm_block_mem
